// ### src/tsd_status_regs.v
// status, press state and channel level register bank with read port
`timescale 1ns/1ps
`include "tsd_defines.vh"

module tsd_status_regs
#(
  parameter CNT_W = 32,
  parameter [63:0] PRESS_LIMIT_CYCLES = `TSD_PRESS_LIMIT_S * `TSD_CLK_HZ
)
(
  input wire clk,
  input wire rst_n,
  input wire rd_en,
  input wire [7:0] rd_addr,
  output reg [7:0] rd_data,
  output reg rd_valid,
  input wire chip_ready,
  input wire regs_writable,
  input wire [3:0] press_chn,
  input wire press_timer_disable,
  input wire sequencer_fault,
  input wire oscillator_start_fault,
  input wire integrity_error,
  input wire capture_busy,
  input wire capture_done,
  input wire [11:0] ch0_level_in,
  input wire [11:0] ch1_level_in,
  input wire [11:0] ch2_level_in,
  input wire [11:0] ch3_level_in
);

  localparam ST_IDLE = 2'b01;
  localparam ST_RESP = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;
  reg flag_any_press;
  reg flag_ready;
  reg flag_writable;
  reg flag_saturated;
  reg flag_seq_fault;
  reg flag_osc_fault;
  reg flag_timeout;
  reg flag_integrity;
  reg data_rdy;
  reg [3:0] press_state;
  reg [11:0] ch0_level;
  reg [11:0] ch1_level;
  reg [11:0] ch2_level;
  reg [CNT_W-1:0] press_cnt [0:3];
  reg [3:0] press_expired;
  reg [7:0] next_rd_data;
  integer i;

  wire rd_status = rd_en && (rd_addr == `TSD_OFS_STATUS);
  wire rd_press = rd_en && (rd_addr == `TSD_OFS_PRESS);
  wire any_saturated;
  wire timeout_event;
  wire [7:0] status_view;
  wire [7:0] press_view;

  // true when a signed 12-bit level sits at either extreme code
  function is_saturated;
    input [11:0] level;
    begin
      is_saturated = (level == `TSD_LEVEL_MAX) ||
                     (level == `TSD_LEVEL_MIN);
    end
  endfunction

  // sticky flag: a set in the clearing cycle wins so no event is lost
  function sticky_next;
    input cur;
    input set;
    input clr;
    begin
      sticky_next = set | (cur & ~clr);
    end
  endfunction

  assign any_saturated = is_saturated(ch0_level_in) |
                         is_saturated(ch1_level_in) |
                         is_saturated(ch2_level_in) |
                         is_saturated(ch3_level_in);

  // one event per press: the counter parks at the limit until release
  assign timeout_event = |press_expired;

  assign status_view = {flag_any_press, flag_ready, flag_writable,
                        flag_saturated, flag_seq_fault, flag_osc_fault,
                        flag_timeout, flag_integrity};

  assign press_view = {3'b000, data_rdy, press_state};

  // press duration timers, one per channel
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < 4; i = i + 1)
        press_cnt[i] <= {CNT_W{1'b0}};
      press_expired <= 4'h0;
    end
    else
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        press_expired[i] <= 1'b0;
        if (!press_chn[i] || press_timer_disable)
          press_cnt[i] <= {CNT_W{1'b0}};
        else if ({{(64-CNT_W){1'b0}}, press_cnt[i]} < PRESS_LIMIT_CYCLES)
        begin
          press_cnt[i] <= press_cnt[i] + {{(CNT_W-1){1'b0}}, 1'b1};
          if ({{(64-CNT_W){1'b0}}, press_cnt[i]} + 64'h1 ==
              PRESS_LIMIT_CYCLES)
            press_expired[i] <= 1'b1;
        end
      end
    end
  end

  // live levels of status bits 6 and 5 and of the press bits
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_ready <= 1'b1;
      flag_writable <= 1'b0;
      press_state <= 4'h0;
    end
    else
    begin
      flag_ready <= chip_ready;
      flag_writable <= regs_writable;
      press_state <= press_chn;
    end
  end

  // sticky status flags cleared by a status read
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_any_press <= 1'b0;
      flag_saturated <= 1'b0;
      flag_seq_fault <= 1'b0;
      flag_osc_fault <= 1'b0;
      flag_timeout <= 1'b0;
      flag_integrity <= 1'b0;
    end
    else
    begin
      flag_any_press <= sticky_next(flag_any_press, |press_chn,
                                    rd_status);
      flag_saturated <= sticky_next(flag_saturated, any_saturated,
                                    rd_status);
      flag_seq_fault <= sticky_next(flag_seq_fault, sequencer_fault,
                                    rd_status);
      flag_osc_fault <= sticky_next(flag_osc_fault,
                                    oscillator_start_fault,
                                    rd_status);
      flag_timeout <= sticky_next(flag_timeout, timeout_event,
                                  rd_status);
      flag_integrity <= sticky_next(flag_integrity, integrity_error,
                                    rd_status);
    end
  end

  // new data flag: completion sets it and wins, capture in progress or a press read clears it
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      data_rdy <= 1'b0;
    else if (capture_done)
      data_rdy <= 1'b1;
    else if (capture_busy || rd_press)
      data_rdy <= 1'b0;
  end

  // levels are latched on capture completion so both bytes stay coherent
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch0_level <= `TSD_RST_LEVEL;
      ch1_level <= `TSD_RST_LEVEL;
      ch2_level <= `TSD_RST_LEVEL;
    end
    else if (capture_done)
    begin
      ch0_level <= ch0_level_in;
      ch1_level <= ch1_level_in;
      ch2_level <= ch2_level_in;
    end
  end

  // read data decode, unmapped offsets read as zero
  always @*
  begin
    case (rd_addr)
      `TSD_OFS_STATUS: next_rd_data = status_view;
      `TSD_OFS_PRESS: next_rd_data = press_view;
      `TSD_OFS_CH0_LO: next_rd_data = ch0_level[7:0];
      `TSD_OFS_CH0_HI: next_rd_data = {4'h0, ch0_level[11:8]};
      `TSD_OFS_CH1_LO: next_rd_data = ch1_level[7:0];
      `TSD_OFS_CH1_HI: next_rd_data = {4'h0, ch1_level[11:8]};
      `TSD_OFS_CH2_LO: next_rd_data = ch2_level[7:0];
      `TSD_OFS_CH2_HI: next_rd_data = {4'h0, ch2_level[11:8]};
      default: next_rd_data = 8'h00;
    endcase
  end

  // read handshake state
  always @*
  begin
    case (state)
      ST_IDLE: next_state = rd_en ? ST_RESP : ST_IDLE;
      ST_RESP: next_state = rd_en ? ST_RESP : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // the snapshot taken is the pre-clear value, so a read reports the event
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      rd_valid <= rd_en;
      if (rd_en)
        rd_data <= next_rd_data;
    end
  end

endmodule

// ### src/tsd_defines.vh
// constants for the touch status and button level register bank
`ifndef TSD_DEFINES_VH
`define TSD_DEFINES_VH

`define TSD_OFS_STATUS 8'h00
`define TSD_OFS_PRESS 8'h01
`define TSD_OFS_CH0_LO 8'h02
`define TSD_OFS_CH0_HI 8'h03
`define TSD_OFS_CH1_LO 8'h04
`define TSD_OFS_CH1_HI 8'h05
`define TSD_OFS_CH2_LO 8'h06
`define TSD_OFS_CH2_HI 8'h07

`define TSD_ST_ANY_PRESS 7
`define TSD_ST_READY 6
`define TSD_ST_WRITABLE 5
`define TSD_ST_SATURATED 4
`define TSD_ST_SEQ_FAULT 3
`define TSD_ST_OSC_FAULT 2
`define TSD_ST_TIMEOUT 1
`define TSD_ST_INTEGRITY 0
`define TSD_PS_DATA_RDY 4

`define TSD_RST_STATUS 8'h40
`define TSD_RST_PRESS 8'h00
`define TSD_RST_LEVEL 12'h000

`define TSD_LEVEL_MAX 12'h7FF
`define TSD_LEVEL_MIN 12'h800

`define TSD_PRESS_LIMIT_S 64'h0000000000000032
`define TSD_CLK_HZ 64'h0000000002FAF080

`endif

// ### dv/tsd_host.sv
// host model issuing register reads on the read port
`timescale 1ns/1ps
module tsd_host (
  input logic clk,
  output logic rd_en,
  output logic [7:0] rd_addr
);
  initial
  begin
    rd_en = 1'b0;
    rd_addr = 8'hA5;
  end
  // request held over the taking edge; back to back reads keep rd_en up
  task rd(input logic [7:0] a);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
  endtask
  // released address keeps changing so a stale offset cannot pass
  task idle(input int n);
    repeat (n)
    begin
      rd_en <= 1'b0;
      rd_addr <= ~rd_addr;
      @(posedge clk);
    end
  endtask
endmodule

// ### dv/tsd_status_regs_sva.sv
// assertions on the read port of the status register bank
`timescale 1ns/1ps
module tsd_status_regs_chk (
  input logic clk,
  input logic rst_n,
  input logic rd_en,
  input logic [7:0] rd_addr,
  input logic [7:0] rd_data,
  input logic rd_valid,
  input logic chip_ready,
  input logic [3:0] press_chn,
  input logic sequencer_fault,
  input logic capture_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire st = rd_en && rd_addr == 8'h00;
  wire ps = rd_en && rd_addr == 8'h01;
  a_valid_after_req: assert property (rd_en |=> rd_valid)
    else $error("no answer to read");
  a_data_held: assert property (!rd_en |=> $stable(rd_data))
    else $error("read data moved");
  a_ready_mirror: assert property (st |=>
    rd_data[6] == $past(chip_ready, 2)) else $error("ready bit wrong");
  a_press_mirror: assert property (ps |=>
    rd_data[3:0] == $past(press_chn, 2)) else $error("press bits wrong");
  a_high_zero: assert property (rd_en && rd_addr inside {3, 5, 7} |=>
    rd_data[7:4] == 4'h0) else $error("high nibble set");
  a_fault_sticky: assert property (sequencer_fault ##1 st |=>
    rd_data[3]) else $error("fault flag lost");
  a_rdy_set: assert property (capture_done ##1 ps |=> rd_data[4])
    else $error("data ready lost");
  a_any_press: assert property ((press_chn != 4'h0) ##1 st |=>
    rd_data[7]) else $error("press summary lost");
  cover property (st ##1 st);
  cover property (capture_done ##1 ps);
  cover property (sequencer_fault && st);
endmodule
bind tsd_status_regs tsd_status_regs_chk u_chk (.clk, .rst_n, .rd_en,
  .rd_addr, .rd_data, .rd_valid, .chip_ready, .press_chn,
  .sequencer_fault, .capture_done);

// ### dv/tb_tsd_status_regs.sv
// self-checking bench for the status register bank
`timescale 1ns/1ps
module tb_tsd_status_regs;
  logic clk, rst_n, chip_ready, regs_writable, press_timer_disable;
  logic capture_busy, capture_done, rd_en, rd_valid;
  logic [2:0] ev;
  logic [3:0] press_chn;
  logic [7:0] rd_addr, rd_data, e;
  logic [11:0] lv [4];
  logic [7:0] q [$];
  logic [7:0] fb [3] = '{8'h01, 8'h04, 8'h08};
  logic [31:0] seed = 32'h4A;
  int failures = 0;
  int n_tests = 0;
  // short press limit keeps the timeout run brief
  tsd_status_regs #(.PRESS_LIMIT_CYCLES(64'h14)) u_tsd_status_regs (
    .clk, .rst_n, .rd_en, .rd_addr, .rd_data, .rd_valid, .chip_ready,
    .regs_writable, .press_chn, .press_timer_disable,
    .sequencer_fault(ev[2]), .oscillator_start_fault(ev[1]),
    .integrity_error(ev[0]), .capture_busy, .capture_done,
    .ch0_level_in(lv[0]), .ch1_level_in(lv[1]), .ch2_level_in(lv[2]),
    .ch3_level_in(lv[3]));
  tsd_host u_tsd_host (.clk, .rd_en, .rd_addr);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task chk(input logic [7:0] a, input logic [7:0] x);
    q.push_back(x);
    u_tsd_host.rd(a);
  endtask
  task wt(input int n);
    u_tsd_host.idle(n);
  endtask
  task stop_test;
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
    if (rd_valid === 1'b1)
    begin
      n_tests++;
      e = q.size() ? q.pop_front() : 8'hXX;
      if (rd_data !== e)
      begin
        failures++;
        $display("Error %0t got %h exp %h", $time, rd_data, e);
      end
    end
  initial
  begin
    #(3000 * 20);
    failures++;
    stop_test();
  end
  initial
  begin
    {rst_n, ev, capture_busy, capture_done, regs_writable} = '0;
    {press_chn, press_timer_disable} = '0;
    chip_ready = 1'b1;
    lv = '{default: 12'h000};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wt(2);
    chk(8'h00, 8'h40);
    chk(8'h01, 8'h00);
    for (int a = 2; a < 9; a++)
      chk(a[7:0], 8'h00);
    chk(8'hFF, 8'h00);
    chip_ready <= 1'b0;
    regs_writable <= 1'b1;
    wt(2);
    chk(8'h00, 8'h20);
    chip_ready <= 1'b1;
    regs_writable <= 1'b0;
    wt(2);
    for (int i = 0; i < 3; i++)
    begin
      ev <= 3'h1 << i;
      chk(8'h00, 8'h40);
      ev <= 3'h0;
      chk(8'h00, 8'h40 | fb[i]);
      chk(8'h00, 8'h40);
    end
    seed = xs(seed);
    press_chn <= seed[3:0] | 4'h1;
    wt(2);
    chk(8'h01, {4'h0, seed[3:0] | 4'h1});
    chk(8'h00, 8'hC0);
    press_chn <= 4'h0;
    wt(3);
    chk(8'h00, 8'hC0);
    chk(8'h00, 8'h40);
    for (int d = 0; d < 2; d++)
    begin
      press_timer_disable <= d[0];
      press_chn <= 4'h8;
      wt(25);
      chk(8'h00, d ? 8'hC0 : 8'hC2);
      chk(8'h00, 8'hC0);
    end
    press_chn <= 4'h0;
    wt(2);
    chk(8'h00, 8'hC0);
    capture_busy <= 1'b1;
    wt(1);
    // odd low bit tied to sign keeps random levels off both extremes
    for (int c = 0; c < 3; c++)
    begin
      seed = xs(seed);
      lv[c] <= {seed[11:1], seed[11]};
    end
    capture_busy <= 1'b0;
    capture_done <= 1'b1;
    wt(1);
    capture_done <= 1'b0;
    chk(8'h01, 8'h10);
    chk(8'h01, 8'h00);
    for (int c = 0; c < 3; c++)
    begin
      chk(8'h02 + 8'(2 * c), lv[c][7:0]);
      chk(8'h03 + 8'(2 * c), {4'h0, lv[c][11:8]});
    end
    // capture in progress must drop a pending new-data bit
    capture_done <= 1'b1;
    wt(1);
    capture_done <= 1'b0;
    capture_busy <= 1'b1;
    wt(1);
    capture_busy <= 1'b0;
    chk(8'h01, 8'h00);
    for (int s = 0; s < 2; s++)
    begin
      lv[3] <= s ? 12'h800 : 12'h7FF;
      wt(1);
      lv[3] <= 12'h000;
      chk(8'h00, 8'h50);
      chk(8'h00, 8'h40);
    end
    wt(2);
    stop_test();
  end
endmodule
